//--- hdl/scs_pkg.sv
/*
 * Constants and types shared by the reference clock selector.
 * Assumes a 10 MHz system clock; all reference inputs are slow enough
 * (well under a quarter of that rate) to be oversampled on it.
 */
package scs_pkg;

  // System clock and loss-of-signal watchdog timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int LOS_WINDOW_NS = 10000;
  localparam int LOS_CYCLES    = LOS_WINDOW_NS / CLK_PERIOD_NS;
  localparam int LOS_CNT_W     = 8;
  localparam logic [LOS_CNT_W-1:0] LOS_LIMIT = LOS_CNT_W'(LOS_CYCLES);

  // Complete cycles a restored input must show before it is used again
  localparam int         RETURN_CYCLES = 4;
  localparam logic [2:0] RETURN_EDGES  = 3'(RETURN_CYCLES + 1);

  // Register map, byte addresses on the bus
  localparam int         ADDR_W    = 4;
  localparam int         DATA_W    = 32;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_DIV  = 4'h4;
  localparam logic [3:0] ADDR_STAT = 4'h8;

  // Control register fields
  localparam int CTRL_MODE_BIT   = 0;
  localparam int CTRL_CHOICE_LSB = 1;
  localparam int CTRL_GUARD_BIT  = 4;

  // Divider register fields
  localparam int DIV_PRI_LSB   = 0;
  localparam int DIV_SEC_LSB   = 2;
  localparam int DIV_RATIO_LSB = 4;

  // Status register fields
  localparam int STAT_CUR_LSB   = 0;
  localparam int STAT_LOST_LSB  = 2;
  localparam int STAT_GOOD_LSB  = 5;
  localparam int STAT_STATE_LSB = 8;

  // Reset values
  localparam logic       MODE_RST   = 1'h1;
  localparam logic [2:0] CHOICE_RST = 3'h3;
  localparam logic       GUARD_RST  = 1'h0;
  localparam logic [1:0] PRE_RST    = 2'h2;
  localparam logic [2:0] RATIO_RST  = 3'h0;

  // Input choice codes: one-hot for a single input, multi-bit for failover
  localparam logic [2:0] CHOICE_PRI   = 3'h1;
  localparam logic [2:0] CHOICE_SEC   = 3'h2;
  localparam logic [2:0] CHOICE_AUX   = 3'h4;
  localparam logic [2:0] CHOICE_AUTO2 = 3'h3;
  localparam logic [2:0] CHOICE_AUTO3 = 3'h7;

  // Pre-divider codes and the divider ratios they map to
  localparam logic [1:0] PREDIV_OFF  = 2'h0;
  localparam logic [1:0] PREDIV_DIV2 = 2'h1;
  localparam logic [1:0] PREDIV_PASS = 2'h2;
  localparam logic [2:0] RATIO_DIV2  = 3'h1;
  localparam logic [2:0] RATIO_PASS  = 3'h0;

  typedef enum logic [1:0] {SRC_PRI, SRC_SEC, SRC_AUX, SRC_NONE} scs_src_t;
  typedef enum logic [1:0] {ST_RUN, ST_LOW, ST_HIGH} scs_state_t;

endpackage : scs_pkg

//--- hdl/scs_clk_if.sv
/*
 * Oversampled clock bundle passed between selector modules.
 * Assumes all fields are driven from flip-flops on the system clock.
 */
`timescale 1ns/1ns
`default_nettype none
interface scs_clk_if;
  logic lvl;   // Filtered level of the clock
  logic rise;  // One-cycle pulse on a rising edge
  logic fall;  // One-cycle pulse on a falling edge
  logic lost;  // Loss of signal

  modport src (output lvl, rise, fall, lost);
  modport snk (input lvl, rise, fall, lost);
endinterface : scs_clk_if
`default_nettype wire

//--- hdl/scs_edge_mon.sv
/*
 * Samples one reference pin, filters it and watches it for loss of signal.
 * Assumes the pin is asynchronous to clk_i and toggles far below its rate.
 */
`timescale 1ns/1ns
`default_nettype none
module scs_edge_mon (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  scs_clk_if.src    mon
);
  typedef struct packed {
    logic [2:0]                     sync;
    logic                           lvl;
    logic                           rise;
    logic                           fall;
    logic [scs_pkg::LOS_CNT_W-1:0]  wd;
    logic                           lost;
  } scs_mon_t;

  scs_mon_t s;
  scs_mon_t next_s;

  // Level changes only once the last two sync stages agree
  always_comb begin
    next_s      = s;
    next_s.sync = {s.sync[1:0], pin_i};
    if (s.sync[1] == s.sync[2]) begin
      next_s.lvl = s.sync[2];
    end
    next_s.rise = next_s.lvl & ~s.lvl;
    next_s.fall = ~next_s.lvl & s.lvl;
    // Watchdog restarts on every rising edge, so recovery is immediate
    if (next_s.rise) begin
      next_s.wd   = '0;
      next_s.lost = 1'h0;
    end else if (s.wd == scs_pkg::LOS_LIMIT) begin
      next_s.lost = 1'h1;
    end else begin
      next_s.wd = s.wd + (scs_pkg::LOS_CNT_W)'(1'h1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign mon.lvl  = s.lvl;
  assign mon.rise = s.rise;
  assign mon.fall = s.fall;
  assign mon.lost = s.lost;

  default clocking mon_cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  watchdog_trip_a: assert property ((s.wd == scs_pkg::LOS_LIMIT) && !next_s.rise |=> s.lost)
    else $error("watchdog expiry did not flag loss");
endmodule : scs_edge_mon
`default_nettype wire

//--- hdl/scs_ratio_div.sv
/*
 * Divides an oversampled clock by ratio plus one, or blocks it.
 * Assumes ratio and enable change rarely; a change mid-count only
 * lengthens one output period.
 */
`timescale 1ns/1ns
`default_nettype none
module scs_ratio_div (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       enable_i,
  input  wire logic [2:0] ratio_i,
  scs_clk_if.snk          din,
  scs_clk_if.src          dout
);
  typedef struct packed {
    logic [2:0] cnt;
    logic       lvl;
    logic       rise;
    logic       fall;
    logic       lost;
  } scs_div_t;

  scs_div_t s;
  scs_div_t next_s;

  // One input high phase passes out of every ratio plus one
  always_comb begin
    next_s = s;
    if (din.rise) begin
      next_s.cnt = (s.cnt >= ratio_i) ? 3'h0 : s.cnt + 3'h1;
    end
    next_s.lvl  = enable_i & din.lvl & (next_s.cnt == 3'h0);
    next_s.rise = next_s.lvl & ~s.lvl;
    next_s.fall = ~next_s.lvl & s.lvl;
    next_s.lost = din.lost | ~enable_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign dout.lvl  = s.lvl;
  assign dout.rise = s.rise;
  assign dout.fall = s.fall;
  assign dout.lost = s.lost;

  default clocking div_cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  count_wrap_a: assert property (din.rise && (s.cnt == ratio_i) |=> (s.cnt == 3'h0))
    else $error("divider count did not wrap at ratio");
  blocked_low_a: assert property (!enable_i |=> !dout.lvl && dout.lost)
    else $error("disconnected input still passes clock");
endmodule : scs_ratio_div
`default_nettype wire

//--- hdl/scs_selector.sv
/*
 * Reference clock selector: three monitored inputs, two pre-dividers,
 * a glitch-free selector with manual, pin and priority failover modes,
 * a reference divider behind the first stage, and a Wishbone slave.
 * Assumes classic Wishbone single cycles on clk_i and reference inputs
 * slow enough to be oversampled at 10 MHz.
 */
// The register addresses and register access over Wishbone were decided locally.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - guard enable bit drives the open-input guard of both differential inputs.
// - manual mode selects primary, secondary or auxiliary from one-hot choice.
// - choice 011 in register mode fails over primary then secondary.
// - choice 111 fails over primary, secondary, then auxiliary.
// - pin mode with choice 011 lets the external pin pick primary or secondary.
// - switching works with any phase between inputs.
// - on loss, switch to next input at its first rising edge.
// - output held low while switching away from a lost input.
// - a restored input must show four complete cycles before reuse.
// - on return, output stays high until the restored clock falls.
// - primary pre-divider code: off, divide by two, pass, reserved.
// - secondary pre-divider code: off, divide by two, pass, reserved.
// - reference divider divides first stage clock by ratio code plus one.
module scs_selector (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [scs_pkg::ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [scs_pkg::DATA_W-1:0] wb_dat_i,
  output logic      [scs_pkg::DATA_W-1:0] wb_dat_o,
  output logic                            wb_ack_o,
  input  wire logic                       primary_reference_i,
  input  wire logic                       secondary_reference_i,
  input  wire logic                       auxiliary_input_i,
  input  wire logic                       reference_choice_pin_i,
  output logic                            auto_selected_clock_o,
  output logic                            reference_divided_clock_o,
  output logic      [1:0]                 active_input_o,
  output logic      [2:0]                 input_lost_o,
  output logic      [1:0]                 open_input_guard_o
);
  typedef struct packed {
    logic                       ack;
    logic [scs_pkg::DATA_W-1:0] dat;
    logic                       mode;
    logic [2:0]                 choice;
    logic                       guard;
    logic [1:0]                 pri_code;
    logic [1:0]                 sec_code;
    logic [2:0]                 ratio;
    logic [2:0]                 pin_sync;
    logic                       pin_lvl;
    logic [2:0][2:0]            good_cnt;
    logic [2:0]                 good;
    scs_pkg::scs_src_t          cur;
    scs_pkg::scs_state_t        st;
    logic                       out;
    logic                       fs_lvl;
    logic                       fs_rise;
    logic                       fs_fall;
    logic                       ref_out;
    logic [1:0]                 guard_out;
    logic [2:0]                 lost_out;
  } scs_sel_t;

  scs_sel_t          s;
  scs_sel_t          next_s;
  scs_pkg::scs_src_t tgt;
  logic [3:0]        src_lvl;
  logic [3:0]        src_rise;
  logic [3:0]        src_fall;
  logic [2:0]        src_lost;
  logic [3:0]        good4;
  logic [1:0][1:0]   pre_code;
  logic              bus_go;
  logic              auto2;
  logic              auto3;
  logic              pin_mode;

  scs_clk_if mon_if[3] ();
  scs_clk_if pre_if[2] ();
  scs_clk_if fs_if ();
  scs_clk_if rdiv_if ();

  // Per-input sampling and watchdog; pre-dividers only on the first two
  assign pre_code = {s.sec_code, s.pri_code};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_in
      scs_edge_mon u_mon (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .pin_i ((gi == 0) ? primary_reference_i :
                (gi == 1) ? secondary_reference_i : auxiliary_input_i),
        .mon   (mon_if[gi])
      );
      if (gi < 2) begin : g_pre
        scs_ratio_div u_pre (
          .clk_i    (clk_i),
          .rst_i    (rst_i),
          .enable_i ((pre_code[gi] == scs_pkg::PREDIV_DIV2) ||
                     (pre_code[gi] == scs_pkg::PREDIV_PASS)),
          .ratio_i  ((pre_code[gi] == scs_pkg::PREDIV_DIV2) ?
                     scs_pkg::RATIO_DIV2 : scs_pkg::RATIO_PASS),
          .din      (mon_if[gi]),
          .dout     (pre_if[gi])
        );
        assign src_lvl[gi]  = pre_if[gi].lvl;
        assign src_rise[gi] = pre_if[gi].rise;
        assign src_fall[gi] = pre_if[gi].fall;
        assign src_lost[gi] = pre_if[gi].lost;
      end else begin : g_raw
        assign src_lvl[gi]  = mon_if[gi].lvl;
        assign src_rise[gi] = mon_if[gi].rise;
        assign src_fall[gi] = mon_if[gi].fall;
        assign src_lost[gi] = mon_if[gi].lost;
      end
    end
  endgenerate

  // The unused index stands for no source; it never toggles
  assign src_lvl[3]  = 1'h0;
  assign src_rise[3] = 1'h0;
  assign src_fall[3] = 1'h0;
  assign good4       = {1'h0, s.good};

  // First stage output feeds the reference divider
  assign fs_if.lvl  = s.fs_lvl;
  assign fs_if.rise = s.fs_rise;
  assign fs_if.fall = s.fs_fall;
  assign fs_if.lost = 1'h0;

  scs_ratio_div u_refdiv (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .enable_i (1'h1),
    .ratio_i  (s.ratio),
    .din      (fs_if),
    .dout     (rdiv_if)
  );

  // Mode decode from the control register
  assign auto2    = s.mode && (s.choice == scs_pkg::CHOICE_AUTO2);
  assign auto3    = s.mode && (s.choice == scs_pkg::CHOICE_AUTO3);
  assign pin_mode = !s.mode && (s.choice == scs_pkg::CHOICE_AUTO2);
  assign bus_go   = wb_cyc_i & wb_stb_i & ~s.ack;

  // Wanted input; failover keeps the current one if nothing is qualified, except auxiliary under choice 011
  always_comb begin
    tgt = scs_pkg::SRC_NONE;
    if (s.mode && (s.choice == scs_pkg::CHOICE_PRI)) begin
      tgt = scs_pkg::SRC_PRI;
    end else if (s.mode && (s.choice == scs_pkg::CHOICE_SEC)) begin
      tgt = scs_pkg::SRC_SEC;
    end else if (s.mode && (s.choice == scs_pkg::CHOICE_AUX)) begin
      tgt = scs_pkg::SRC_AUX;
    end else if (auto2 || auto3) begin
      if (s.good[0]) begin
        tgt = scs_pkg::SRC_PRI;
      end else if (s.good[1]) begin
        tgt = scs_pkg::SRC_SEC;
      end else if (auto3 && s.good[2]) begin
        tgt = scs_pkg::SRC_AUX;
      end else if (auto3 || (s.cur != scs_pkg::SRC_AUX)) begin
        tgt = s.cur;
      end
    end else if (pin_mode) begin
      tgt = s.pin_lvl ? scs_pkg::SRC_SEC : scs_pkg::SRC_PRI;
    end
  end

  // Bus, qualification counters and the switching state machine
  always_comb begin
    next_s     = s;
    next_s.ack = bus_go;
    next_s.dat = '0;
    if (bus_go) begin
      case (wb_adr_i)
        scs_pkg::ADDR_CTRL: begin
          next_s.dat[scs_pkg::CTRL_MODE_BIT]                       = s.mode;
          next_s.dat[scs_pkg::CTRL_CHOICE_LSB +: 3]                = s.choice;
          next_s.dat[scs_pkg::CTRL_GUARD_BIT]                      = s.guard;
          if (wb_we_i && wb_sel_i[0]) begin
            next_s.mode   = wb_dat_i[scs_pkg::CTRL_MODE_BIT];
            next_s.choice = wb_dat_i[scs_pkg::CTRL_CHOICE_LSB +: 3];
            next_s.guard  = wb_dat_i[scs_pkg::CTRL_GUARD_BIT];
          end
        end
        scs_pkg::ADDR_DIV: begin
          next_s.dat[scs_pkg::DIV_PRI_LSB +: 2]   = s.pri_code;
          next_s.dat[scs_pkg::DIV_SEC_LSB +: 2]   = s.sec_code;
          next_s.dat[scs_pkg::DIV_RATIO_LSB +: 3] = s.ratio;
          if (wb_we_i && wb_sel_i[0]) begin
            next_s.pri_code = wb_dat_i[scs_pkg::DIV_PRI_LSB +: 2];
            next_s.sec_code = wb_dat_i[scs_pkg::DIV_SEC_LSB +: 2];
            next_s.ratio    = wb_dat_i[scs_pkg::DIV_RATIO_LSB +: 3];
          end
        end
        scs_pkg::ADDR_STAT: begin
          next_s.dat[scs_pkg::STAT_CUR_LSB +: 2]   = s.cur;
          next_s.dat[scs_pkg::STAT_LOST_LSB +: 3]  = src_lost;
          next_s.dat[scs_pkg::STAT_GOOD_LSB +: 3]  = s.good;
          next_s.dat[scs_pkg::STAT_STATE_LSB +: 2] = s.st;
        end
        default: begin
          next_s.dat = '0;  // Unmapped: acknowledged, reads zero
        end
      endcase
    end

    // Selection pin: three stages, change taken once the last two agree
    next_s.pin_sync = {s.pin_sync[1:0], reference_choice_pin_i};
    if (s.pin_sync[1] == s.pin_sync[2]) begin
      next_s.pin_lvl = s.pin_sync[2];
    end

    // An input regains priority only after its first edge plus four periods
    for (int i = 0; i < 3; i++) begin
      if (src_lost[i]) begin
        next_s.good_cnt[i] = 3'h0;
        next_s.good[i]     = 1'h0;
      end else if (src_rise[i] && !s.good[i]) begin
        next_s.good_cnt[i] = s.good_cnt[i] + 3'h1;
        if (next_s.good_cnt[i] == scs_pkg::RETURN_EDGES) begin
          next_s.good[i] = 1'h1;
        end
      end
    end

    // Edges are only waited for, never compared, so any phase works
    case (s.st)
      scs_pkg::ST_RUN: begin
        next_s.out = src_lvl[s.cur];
        if (tgt != s.cur) begin
          // Only a failover return stretches the high phase; manual and pin
          // switches go through the low path, as the target need not be qualified
          if ((auto2 || auto3) && (s.cur != scs_pkg::SRC_NONE) && (tgt < s.cur)
              && !src_lost[s.cur]) begin
            // Return upward: wait for a high phase, then stretch it
            if (src_rise[s.cur]) begin
              next_s.st  = scs_pkg::ST_HIGH;
              next_s.out = 1'h1;
            end
          end else begin
            next_s.st  = scs_pkg::ST_LOW;
            next_s.out = 1'h0;
          end
        end
      end
      scs_pkg::ST_LOW: begin
        next_s.out = 1'h0;
        if (tgt == scs_pkg::SRC_NONE) begin
          next_s.cur = scs_pkg::SRC_NONE;
          next_s.st  = scs_pkg::ST_RUN;
        end else if (src_rise[tgt]) begin
          next_s.cur = tgt;
          next_s.st  = scs_pkg::ST_RUN;
          next_s.out = 1'h1;
        end
      end
      scs_pkg::ST_HIGH: begin
        next_s.out = 1'h1;
        if (tgt == s.cur) begin
          next_s.st  = scs_pkg::ST_RUN;
          next_s.out = src_lvl[s.cur];
        end else if ((tgt > s.cur) || src_lost[s.cur]) begin
          next_s.st  = scs_pkg::ST_LOW;
          next_s.out = 1'h0;
        end else if (src_fall[tgt]) begin
          next_s.cur = tgt;
          next_s.st  = scs_pkg::ST_RUN;
          next_s.out = 1'h0;
        end
      end
      default: begin
        next_s.st  = scs_pkg::ST_LOW;
        next_s.out = 1'h0;
      end
    endcase

    // First stage carries only primary or secondary into the divider
    next_s.fs_lvl    = next_s.out && (next_s.cur != scs_pkg::SRC_AUX);
    next_s.fs_rise   = next_s.fs_lvl & ~s.fs_lvl;
    next_s.fs_fall   = ~next_s.fs_lvl & s.fs_lvl;
    next_s.ref_out   = rdiv_if.lvl;
    next_s.guard_out = {2{s.guard}};
    next_s.lost_out  = src_lost;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s          <= '0;
      s.mode     <= scs_pkg::MODE_RST;
      s.choice   <= scs_pkg::CHOICE_RST;
      s.guard    <= scs_pkg::GUARD_RST;
      s.pri_code <= scs_pkg::PRE_RST;
      s.sec_code <= scs_pkg::PRE_RST;
      s.ratio    <= scs_pkg::RATIO_RST;
      s.cur      <= scs_pkg::SRC_NONE;
      s.st       <= scs_pkg::ST_RUN;
    end else begin
      s <= next_s;
    end
  end

  // Every output straight from the state register
  assign wb_ack_o                  = s.ack;
  assign wb_dat_o                  = s.dat;
  assign auto_selected_clock_o     = s.out;
  assign reference_divided_clock_o = s.ref_out;
  assign active_input_o            = s.cur;
  assign input_lost_o              = s.lost_out;
  assign open_input_guard_o        = s.guard_out;

  default clocking sel_cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  guard_follow_a: assert property (##1 open_input_guard_o == {2{$past(s.guard)}})
    else $error("open-input guard does not follow its enable");
  manual_pick_a: assert property (s.mode && (s.choice == scs_pkg::CHOICE_SEC)
                                  |-> tgt == scs_pkg::SRC_SEC)
    else $error("manual choice not honoured");
  auto_primary_a: assert property (auto2 && s.good[0] |-> tgt == scs_pkg::SRC_PRI)
    else $error("qualified primary not preferred");
  auto_aux_a: assert property (auto3 && !s.good[0] && !s.good[1] && s.good[2]
                               |-> tgt == scs_pkg::SRC_AUX)
    else $error("auxiliary not used as last fallback");
  pin_select_a: assert property (pin_mode |-> tgt == (s.pin_lvl ? scs_pkg::SRC_SEC
                                                               : scs_pkg::SRC_PRI))
    else $error("pin selection not honoured");
  switch_edge_a: assert property ((s.st == scs_pkg::ST_LOW) && (tgt != scs_pkg::SRC_NONE)
                                  && src_rise[tgt] |=> (s.st == scs_pkg::ST_RUN)
                                  && (s.cur == $past(tgt)) && auto_selected_clock_o)
    else $error("switch not taken on fallback rising edge");
  hold_low_a: assert property ((s.st == scs_pkg::ST_LOW) && !src_rise[tgt]
                               |=> !auto_selected_clock_o)
    else $error("output not low during switch");
  return_good_a: assert property ($rose(s.st == scs_pkg::ST_HIGH) |-> good4[tgt])
    else $error("return started before input qualified");
  hold_high_a: assert property ((s.st == scs_pkg::ST_HIGH) && (tgt < s.cur) && !src_fall[tgt]
                                && !src_lost[s.cur] |=> auto_selected_clock_o)
    else $error("output not held high during return");
  bus_ack_a: assert property (bus_go |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus acknowledge not a single cycle");

  cover_fail_low_c:  cover property ((s.st == scs_pkg::ST_LOW) ##[1:200] (s.st == scs_pkg::ST_RUN));
  cover_return_c:    cover property ((s.st == scs_pkg::ST_HIGH) ##[1:200] (s.st == scs_pkg::ST_RUN));
  cover_aux_c:       cover property (auto3 && (s.cur == scs_pkg::SRC_AUX));
  cover_bus_write_c: cover property (bus_go && wb_we_i && (wb_adr_i == scs_pkg::ADDR_CTRL));
endmodule : scs_selector
`default_nettype wire

//--- sim/scs_ref_model.sv
/*
 * Three reference clock sources standing beside the selector.
 * Assumes clk_i is the 10 MHz bench clock; sources are derived from it.
 */
`timescale 1ns/1ns
`default_nettype none
module scs_ref_model (
  input  wire logic       clk_i,
  input  wire logic [2:0] run_i,
  output logic      [2:0] ref_o
);
  logic [3:0] cnt [3];

  // Offset start phases: the sources do not start with aligned edges
  initial begin
    ref_o = 3'h0;
    cnt[0] = 4'h0;
    cnt[1] = 4'h2;
    cnt[2] = 4'h3;
  end

  // Half periods of 6 and 7 cycles keep sources within 20%
  // A stopped source stands low, as a dead driver would
  always @(posedge clk_i) begin
    for (int i = 0; i < 3; i++) begin
      cnt[i] <= (cnt[i] == 4'(5 + (i % 2))) ? 4'h0 : cnt[i] + 4'h1;
      if (cnt[i] == 4'h0) ref_o[i] <= run_i[i] & ~ref_o[i];
    end
  end
endmodule : scs_ref_model
`default_nettype wire

//--- sim/scs_selector_tb_top.sv
/*
 * Self-checking bench for the reference clock selector.
 * Assumes the source model above and Wishbone classic cycles.
 */
`timescale 1ns/1ns
`default_nettype none
module scs_selector_tb_top;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc, stb, we, pin, ack;
  logic [3:0]  adr;
  logic [31:0] dat, rdat, q;
  logic [2:0]  run, refs, lost;
  logic [1:0]  act, guard;
  logic        sclk, rclk;
  int          per;
  int          fail_count = 0;
  int          n_checks = 0;

  always #50 clk_i = ~clk_i;

  scs_ref_model src (.clk_i(clk_i), .run_i(run), .ref_o(refs));

  scs_selector dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .primary_reference_i(refs[0]), .secondary_reference_i(refs[1]),
    .auxiliary_input_i(refs[2]), .reference_choice_pin_i(pin),
    .auto_selected_clock_o(sclk), .reference_divided_clock_o(rclk), .active_input_o(act),
    .input_lost_o(lost), .open_input_guard_o(guard));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One classic cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic go(input int n);
    repeat (n) @(posedge clk_i);
  endtask : go

  // Cycles from one rising edge of a clock output to the next, seen on clk_i
  task automatic period(input logic pick, output int n);
    logic now, prev;
    int   e;
    e = 0;
    n = 0;
    prev = 1'b1;
    repeat (400) begin
      @(posedge clk_i);
      now = pick ? rclk : sclk;
      if (now && !prev) e++;
      if (e == 1) n++;
      prev = now;
    end
  endtask : period

  task automatic end_sim;
    if (fail_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim

  // Watchdog well beyond the roughly 2600 cycles the tests need
  initial begin
    go(20000);
    fail_count++;
    end_sim();
  end

  initial begin
    {cyc, stb, we, pin} = 4'h0;
    adr = 4'h0;
    dat = 32'h0;
    run = 3'h7;
    go(6);
    rst_i <= 1'b0;
    go(1);
    wb(0, scs_pkg::ADDR_CTRL, 0); check("ctrl", q, 32'h7);
    wb(0, scs_pkg::ADDR_DIV, 0); check("div", q, 32'ha);
    wb(0, 4'hc, 0); check("unmapped", q, 32'h0);
    wb(1, scs_pkg::ADDR_CTRL, 32'h17); go(150);
    check("guard", guard, 32'h3);
    check("auto pri", act, 32'h0);
    run <= 3'h6; go(200);
    check("pri lost", lost[0], 32'h1);
    check("to sec", act, 32'h1);
    run <= 3'h7; go(200);
    check("back pri", act, 32'h0);
    wb(1, scs_pkg::ADDR_CTRL, 32'hf); run <= 3'h4; go(300);
    check("to aux", act, 32'h2);
    wb(0, scs_pkg::ADDR_STAT, 0); check("stat", q, 32'h8e);
    run <= 3'h7;
    for (int i = 0; i < 3; i++) begin
      wb(1, scs_pkg::ADDR_CTRL, 32'(1 | (2 << i))); go(100);
      check("manual", act, 32'(i));
    end
    // Pin mode: the outside party picks the source
    wb(1, scs_pkg::ADDR_CTRL, 32'h6); pin <= 1'b1; go(100);
    check("pin sec", act, 32'h1);
    pin <= 1'b0; go(100);
    check("pin pri", act, 32'h0);
    // Primary halved, reference divider at four: 12-cycle source gives 24 and 96
    wb(1, scs_pkg::ADDR_DIV, 32'h39); go(200);
    period(1'b0, per); check("pri div2 period", per, 32'h18);
    period(1'b1, per); check("ref div4 period", per, 32'h60);
    wb(1, scs_pkg::ADDR_DIV, 32'h0); go(200);
    check("prediv off", lost[1:0], 32'h3);
    end_sim();
  end
endmodule : scs_selector_tb_top
`default_nettype wire
